// ==== common/dsp_defines.svh ====
// register offsets, field positions, reset values and timing counts of the serial port
`ifndef DSP_DEFINES_SVH
`define DSP_DEFINES_SVH
// ----------------------------------------------------------------
// register word offsets (byte address on the bus is the offset times four)
// ----------------------------------------------------------------
`define DSP_OFF_CLKSEL   6'h00
`define DSP_OFF_STATUS   6'h01
`define DSP_OFF_CTL1     6'h02
`define DSP_OFF_CTL2     6'h03
`define DSP_OFF_DIV      6'h04
`define DSP_OFF_DATA     6'h05
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DSP_C1_EN        7
`define DSP_C1_NINE      6
`define DSP_C1_PAREN     5
`define DSP_C1_PARODD    4
`define DSP_C1_TWOSTOP   3
`define DSP_C1_BRK       2
`define DSP_C1_RX8       1
`define DSP_C1_TX8       0
`define DSP_C2_TXEN      7
`define DSP_C2_RXEN      6
`define DSP_C2_BRGH      5
`define DSP_C2_ADDEN     4
`define DSP_C2_WAKE      3
`define DSP_C2_RIE       2
`define DSP_C2_TIIE      1
`define DSP_C2_TEIE      0
// ----------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------
`define DSP_STATUS_RST   8'h0B
`define DSP_FIFO_DEPTH   2'h2
`define DSP_OS_CENTER    4'h8
`define DSP_OS_LAST      4'hF
`define DSP_LOWSPD_LAST  2'h3
`endif

// ==== common/dsp_pkg.sv ====
// types shared by the serial port
package dsp_pkg;
    typedef enum logic [2:0] {
        TX_IDLE  = 3'b000,
        TX_START = 3'b001,
        TX_DATA  = 3'b010,
        TX_PAR   = 3'b011,
        TX_STOP  = 3'b100
    } dsp_tx_st_t;
    typedef enum logic [2:0] {
        RX_IDLE  = 3'b000,
        RX_START = 3'b001,
        RX_DATA  = 3'b010,
        RX_PAR   = 3'b011,
        RX_STOP  = 3'b100
    } dsp_rx_st_t;
    typedef struct packed {
        logic [2:0]      cs1;
        logic [2:0]      cs0;
        logic [7:0]      c1;
        logic [7:0]      c2;
        logic [7:0]      div;
        logic [7:0]      pre;
        logic [1:0]      hs;
        logic            os;
        logic [8:0]      hold;
        logic            hold_full;
        dsp_tx_st_t      tx_st;
        logic [8:0]      tx_sh;
        logic [3:0]      tx_cnt;
        logic [3:0]      tx_ph;
        logic            tx_par;
        dsp_rx_st_t      rx_st;
        logic [8:0]      rx_sh;
        logic [3:0]      rx_cnt;
        logic [3:0]      rx_ph;
        logic [1:0]      rx_smp;
        logic            rx_noise;
        logic            rx_pbit;
        logic            rx_prev;
        logic [1:0][8:0] fifo;
        logic            hd;
        logic [1:0]      cnt;
        logic            perr;
        logic            nf;
        logic            ferr;
        logic            oerr;
        logic            sr_seen;
        logic            sync1;
        logic            sync2;
        logic            ack;
        logic [7:0]      dat;
    } dsp_state_t;
endpackage

// ==== logic/dsp_uart.sv ====
// one asynchronous serial port with a classic wishbone register slave
//
// How it works
// - character carries 8 or 9 data bits, chosen by one control bit for both ways
// - parity is even, odd or absent, set by configuration
// - one or two stop bits, the receiver expects the same count
// - both directions clock off a baud generator using an 8-bit divisor
// - receiver flags parity, framing, noise and overrun errors
// - with address detect on, only characters with last data bit one are kept
// - transmitter and receiver have separate enables
// - received characters queue in a two entry fifo
// - low level on the receive pin can wake the chip when the port and wake are both enabled
// - interrupt on tx empty, tx idle, rx data, rx overrun
// - enabled port drives tx pin, takes rx pin, disconnects pull-ups
// - disabled port or direction floats the pin, pull-up left to gpio
// - written byte moves to a hidden shift register, sent lsb first
// - received bits shift in lsb first, full character goes to read data
// - one data address: writes load tx holding, reads return rx data
// - clock select code 0,6,7 system clock, 1..4 pll outputs, 5 unused
// - port 1 select in bits 6..4, port 0 select in bits 2..0
// - clock select bits 7 and 3 read zero, fields reset to zero
// - status read only; reset shows idle flags and tx empty set, others clear
// - parity error set on wrong parity, only with parity enabled
// - error flags clear on status read followed by data access
// - port disable flushes fifo, resets baud count, clears enables and flags
// - rx available clears on the data read that empties the fifo, no status read needed
`timescale 1ns/100ps
`include "dsp_defines.svh"
module dsp_uart #(
    parameter int PORT_IDX = 0
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       wb_cyc_i,
    input  wire logic       wb_stb_i,
    input  wire logic       wb_we_i,
    input  wire logic [7:0] wb_adr_i,
    input  wire logic [3:0] wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic            wb_ack_o,
    input  wire logic [3:0] pll_tick_i,
    input  wire logic       rx_pin_i,
    output logic            tx_pin_o,
    output logic            tx_pin_oe_o,
    output logic            tx_pullup_off_o,
    output logic            rx_pullup_off_o,
    output logic            wake_o,
    output logic            irq_o
);
    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (PORT_IDX < 0 || PORT_IDX > 1) begin : g_bad_port
        $error("dsp_uart: PORT_IDX must be 0 or 1");
    end

    dsp_pkg::dsp_state_t st_r;
    dsp_pkg::dsp_state_t st_nxt;

    logic       en;
    logic       txen;
    logic       rxen;
    logic       tx_line;
    logic [7:0] status;
    logic       tidle;
    logic       txif;
    logic       rxif;
    logic       ridle;

    assign en    = st_r.c1[`DSP_C1_EN];
    assign txen  = en & st_r.c2[`DSP_C2_TXEN];
    assign rxen  = en & st_r.c2[`DSP_C2_RXEN];
    assign txif  = ~st_r.hold_full;
    assign rxif  = (st_r.cnt != 2'h0);
    assign ridle = (st_r.rx_st == dsp_pkg::RX_IDLE);
    // idle only when nothing is queued, shifting or breaking
    assign tidle = txif & (st_r.tx_st == dsp_pkg::TX_IDLE) & ~st_r.c1[`DSP_C1_BRK];
    assign status = {st_r.perr, st_r.nf, st_r.ferr, st_r.oerr, ridle, rxif, tidle, txif};

    // ----------------------------------------------------------------
    // pins and requests
    // ----------------------------------------------------------------
    always_comb begin
        unique case (st_r.tx_st)
            dsp_pkg::TX_START: tx_line = 1'b0;
            dsp_pkg::TX_DATA:  tx_line = st_r.tx_sh[0];
            dsp_pkg::TX_PAR:   tx_line = st_r.tx_par;
            default:           tx_line = 1'b1;
        endcase
    end
    assign tx_pin_o        = tx_line & ~st_r.c1[`DSP_C1_BRK];
    assign tx_pin_oe_o     = txen;
    assign tx_pullup_off_o = txen;
    assign rx_pullup_off_o = rxen;
    assign wake_o = en & st_r.c2[`DSP_C2_WAKE] & ~st_r.sync2;
    assign irq_o  = (st_r.c2[`DSP_C2_RIE] & (rxif | st_r.oerr))
                  | (st_r.c2[`DSP_C2_TIIE] & tidle)
                  | (st_r.c2[`DSP_C2_TEIE] & txif);
    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = {24'h000000, st_r.dat};

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [5:0] idx;
        logic       req;
        logic       go;
        logic       src;
        logic [3:0] nb;
        logic       rx_in;
        logic       maj;
        logic [8:0] rxd;
        logic [8:0] txd;
        logic [7:0] rd;
        idx   = wb_adr_i[7:2];
        req   = wb_cyc_i & wb_stb_i;
        go    = req & st_r.ack;
        src   = 1'b0;
        nb    = st_r.c1[`DSP_C1_NINE] ? 4'h9 : 4'h8;
        rx_in = rxen ? st_r.sync2 : 1'b1;
        maj   = 1'b0;
        rxd   = 9'h000;
        txd   = 9'h000;
        rd    = 8'h00;
        st_nxt = st_r;
        st_nxt.sync1 = rx_pin_i;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.rx_prev = rx_in;

        // bus slave: answer one cycle after the request, drop the next cycle
        st_nxt.ack = req & ~st_r.ack;
        unique case (idx)
            `DSP_OFF_CLKSEL: rd = {1'b0, st_r.cs1, 1'b0, st_r.cs0};
            `DSP_OFF_STATUS: rd = status;
            `DSP_OFF_CTL1:   rd = {st_r.c1[7:2], st_r.fifo[st_r.hd][8], 1'b0};
            `DSP_OFF_CTL2:   rd = st_r.c2;
            `DSP_OFF_DIV:    rd = st_r.div;
            `DSP_OFF_DATA:   rd = st_r.fifo[st_r.hd][7:0];
            default:         rd = 8'h00;
        endcase
        if (req & ~st_r.ack) begin
            st_nxt.dat = rd;
        end

        // register side effects at the edge where the master sees ack
        if (go & wb_we_i & wb_sel_i[0]) begin
            unique case (idx)
                `DSP_OFF_CLKSEL: begin
                    st_nxt.cs1 = wb_dat_i[6:4];
                    st_nxt.cs0 = wb_dat_i[2:0];
                end
                `DSP_OFF_CTL1: st_nxt.c1 = {wb_dat_i[7:2], 1'b0, wb_dat_i[0]};
                `DSP_OFF_CTL2: st_nxt.c2 = wb_dat_i[7:0];
                `DSP_OFF_DIV:  st_nxt.div = wb_dat_i[7:0];
                `DSP_OFF_DATA: begin
                    // a write while the holding register is full is dropped
                    if (~st_r.hold_full & txen) begin
                        st_nxt.hold = {st_r.c1[`DSP_C1_TX8], wb_dat_i[7:0]};
                        st_nxt.hold_full = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        if (go & ~wb_we_i & (idx == `DSP_OFF_STATUS)) begin
            st_nxt.sr_seen = 1'b1;
        end
        if (go & (idx == `DSP_OFF_DATA)) begin
            st_nxt.sr_seen = 1'b0;
            if (st_r.sr_seen) begin
                st_nxt.perr = 1'b0;
                st_nxt.nf   = 1'b0;
                st_nxt.ferr = 1'b0;
                st_nxt.oerr = 1'b0;
            end
            if (~wb_we_i & rxif) begin
                st_nxt.hd  = ~st_r.hd;
                st_nxt.cnt = st_r.cnt - 2'h1;
            end
        end

        // baud generator: 16 samples per bit, low speed adds a divide by four
        unique case (PORT_IDX == 1 ? st_r.cs1 : st_r.cs0)
            3'h1:    src = pll_tick_i[0];
            3'h2:    src = pll_tick_i[1];
            3'h3:    src = pll_tick_i[2];
            3'h4:    src = pll_tick_i[3];
            3'h5:    src = 1'b0;
            default: src = 1'b1;
        endcase
        st_nxt.os = 1'b0;
        if (src) begin
            if (st_r.pre == st_r.div) begin
                st_nxt.pre = 8'h00;
                st_nxt.hs  = st_r.hs + 2'h1;
                st_nxt.os  = st_r.c2[`DSP_C2_BRGH] | (st_r.hs == `DSP_LOWSPD_LAST);
            end else begin
                st_nxt.pre = st_r.pre + 8'h01;
            end
        end

        // transmitter
        txd = st_r.c1[`DSP_C1_NINE] ? st_r.hold : {1'b0, st_r.hold[7:0]};
        if (st_r.tx_st == dsp_pkg::TX_IDLE) begin
            if (st_r.hold_full & txen & ~st_r.c1[`DSP_C1_BRK]) begin
                st_nxt.tx_sh  = txd;
                st_nxt.tx_par = ^txd ^ st_r.c1[`DSP_C1_PARODD];
                st_nxt.hold_full = 1'b0;
                st_nxt.tx_st  = dsp_pkg::TX_START;
                st_nxt.tx_ph  = 4'h0;
                st_nxt.tx_cnt = 4'h0;
            end
        end else if (st_r.os) begin
            st_nxt.tx_ph = st_r.tx_ph + 4'h1;
            if (st_r.tx_ph == `DSP_OS_LAST) begin
                unique case (st_r.tx_st)
                    dsp_pkg::TX_START: st_nxt.tx_st = dsp_pkg::TX_DATA;
                    dsp_pkg::TX_DATA: begin
                        st_nxt.tx_sh  = {1'b0, st_r.tx_sh[8:1]};
                        st_nxt.tx_cnt = st_r.tx_cnt + 4'h1;
                        if (st_r.tx_cnt == nb - 4'h1) begin
                            st_nxt.tx_cnt = 4'h0;
                            st_nxt.tx_st  = st_r.c1[`DSP_C1_PAREN] ? dsp_pkg::TX_PAR
                                                                   : dsp_pkg::TX_STOP;
                        end
                    end
                    dsp_pkg::TX_PAR: st_nxt.tx_st = dsp_pkg::TX_STOP;
                    default: begin
                        if (st_r.c1[`DSP_C1_TWOSTOP] & (st_r.tx_cnt == 4'h0)) begin
                            st_nxt.tx_cnt = 4'h1;
                        end else begin
                            st_nxt.tx_st = dsp_pkg::TX_IDLE;
                        end
                    end
                endcase
            end
        end

        // receiver: majority of three samples around the bit centre
        rxd = st_r.c1[`DSP_C1_NINE] ? st_r.rx_sh : {1'b0, st_r.rx_sh[8:1]};
        if (st_r.rx_st == dsp_pkg::RX_IDLE) begin
            if (st_r.rx_prev & ~rx_in) begin
                st_nxt.rx_st    = dsp_pkg::RX_START;
                st_nxt.rx_ph    = 4'h0;
                st_nxt.rx_cnt   = 4'h0;
                st_nxt.rx_noise = 1'b0;
            end
        end else if (st_r.os) begin
            st_nxt.rx_ph = st_r.rx_ph + 4'h1;
            if (st_r.rx_ph == `DSP_OS_CENTER - 4'h1) begin
                st_nxt.rx_smp[0] = rx_in;
            end
            if (st_r.rx_ph == `DSP_OS_CENTER) begin
                st_nxt.rx_smp[1] = rx_in;
            end
            if (st_r.rx_ph == `DSP_OS_CENTER + 4'h1) begin
                maj = (st_r.rx_smp[0] & st_r.rx_smp[1]) | (rx_in & (st_r.rx_smp[0]
                      | st_r.rx_smp[1]));
                if ((st_r.rx_smp[0] != rx_in) | (st_r.rx_smp[1] != rx_in)) begin
                    st_nxt.rx_noise = 1'b1;
                end
                unique case (st_r.rx_st)
                    dsp_pkg::RX_START: begin
                        // a start bit that is high at its centre was a glitch
                        st_nxt.rx_st = maj ? dsp_pkg::RX_IDLE : dsp_pkg::RX_DATA;
                    end
                    dsp_pkg::RX_DATA: begin
                        st_nxt.rx_sh  = {maj, st_r.rx_sh[8:1]};
                        st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
                        if (st_r.rx_cnt == nb - 4'h1) begin
                            st_nxt.rx_cnt = 4'h0;
                            st_nxt.rx_st  = st_r.c1[`DSP_C1_PAREN] ? dsp_pkg::RX_PAR
                                                                   : dsp_pkg::RX_STOP;
                        end
                    end
                    dsp_pkg::RX_PAR: begin
                        st_nxt.rx_pbit = maj;
                        st_nxt.rx_st   = dsp_pkg::RX_STOP;
                    end
                    default: begin
                        if (st_r.c1[`DSP_C1_TWOSTOP] & (st_r.rx_cnt == 4'h0) & maj) begin
                            st_nxt.rx_cnt = 4'h1;
                        end else begin
                            st_nxt.rx_st = dsp_pkg::RX_IDLE;
                            if (st_r.c2[`DSP_C2_ADDEN] & ~rxd[nb - 4'h1]) begin
                                st_nxt.rx_st = dsp_pkg::RX_IDLE;
                            end else if (st_r.oerr | (st_nxt.cnt == `DSP_FIFO_DEPTH)) begin
                                st_nxt.oerr = 1'b1;
                            end else begin
                                st_nxt.fifo[st_nxt.hd ^ st_nxt.cnt[0]] = rxd;
                                st_nxt.cnt  = st_nxt.cnt + 2'h1;
                                // build on the cleared copy so a clear in this cycle survives
                                st_nxt.ferr = st_nxt.ferr | ~maj;
                                st_nxt.nf   = st_nxt.nf | st_nxt.rx_noise;
                                st_nxt.perr = st_nxt.perr | (st_r.c1[`DSP_C1_PAREN] &
                                    (st_r.rx_pbit ^ (^rxd) ^ st_r.c1[`DSP_C1_PARODD]));
                            end
                        end
                    end
                endcase
            end
        end

        // disabled port: state returns to idle, enables and break clear, other configuration kept
        if (~st_nxt.c1[`DSP_C1_EN]) begin
            st_nxt.c2[`DSP_C2_TXEN] = 1'b0;
            st_nxt.c2[`DSP_C2_RXEN] = 1'b0;
            st_nxt.c1[`DSP_C1_BRK]  = 1'b0;
            st_nxt.pre = 8'h00;
            st_nxt.hs  = 2'h0;
            st_nxt.os  = 1'b0;
            st_nxt.cnt = 2'h0;
            st_nxt.hold_full = 1'b0;
            st_nxt.tx_st = dsp_pkg::TX_IDLE;
            st_nxt.rx_st = dsp_pkg::RX_IDLE;
            st_nxt.perr = 1'b0;
            st_nxt.nf   = 1'b0;
            st_nxt.ferr = 1'b0;
            st_nxt.oerr = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
            st_r.sync1   <= 1'b1;
            st_r.sync2   <= 1'b1;
            st_r.rx_prev <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_single: assert property (st_r.ack |=> !st_r.ack)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property ((wb_cyc_i && wb_stb_i && !st_r.ack) |=> st_r.ack)
        else $error("request not answered next cycle");
    a_clksel_zero: assert property ((wb_cyc_i && wb_stb_i && !st_r.ack && !wb_we_i &&
        wb_adr_i[7:2] == `DSP_OFF_CLKSEL) |=> (st_r.dat[7] == 1'b0 && st_r.dat[3] == 1'b0))
        else $error("clock select reserved bits not zero");
    a_disable_flags: assert property (!st_nxt.c1[`DSP_C1_EN] |=>
        (status == `DSP_STATUS_RST && !tx_pin_oe_o && !rx_pullup_off_o))
        else $error("disabled port not idle");
    a_fifo_bound: assert property (st_r.cnt <= `DSP_FIFO_DEPTH)
        else $error("fifo count above depth");
    a_overrun_cause: assert property ($rose(st_r.oerr) |-> $past(st_r.cnt) == `DSP_FIFO_DEPTH)
        else $error("overrun without a full fifo");
    a_parity_only: assert property ($rose(st_r.perr) |-> $past(st_r.c1[`DSP_C1_PAREN]))
        else $error("parity error with parity off");
    a_tx_float: assert property (!txen |-> !tx_pin_oe_o && !tx_pullup_off_o)
        else $error("tx pin driven while disabled");
    a_tx_idle_high: assert property ((st_r.tx_st == dsp_pkg::TX_IDLE &&
        !st_r.c1[`DSP_C1_BRK]) |-> tx_pin_o)
        else $error("tx line low while idle");
    a_tx_start_low: assert property ((st_r.tx_st == dsp_pkg::TX_IDLE) ##1
        (st_r.tx_st == dsp_pkg::TX_START) |-> !tx_pin_o [*2])
        else $error("start bit not low");
    a_tx_hold_take: assert property ((st_r.hold_full && txen && st_r.c1[`DSP_C1_EN] &&
        st_r.tx_st == dsp_pkg::TX_IDLE && !st_r.c1[`DSP_C1_BRK]) |=>
        (st_r.tx_st == dsp_pkg::TX_START && !st_r.hold_full))
        else $error("holding register not taken by the shifter");
    a_rx_float: assert property (!rxen |-> !rx_pullup_off_o)
        else $error("rx pull-up disconnected while disabled");
    a_break_low: assert property (st_r.c1[`DSP_C1_BRK] |-> !tx_pin_o)
        else $error("tx line high during break");
endmodule

// ==== test/dsp_serial_dev.sv ====
// behavioural model of the external serial device on the port's pins
`timescale 1ns/100ps
module dsp_serial_dev #(
    parameter int BIT_CLK = 32
) (
    input  wire logic clk_i,
    input  wire logic line_i,
    output logic      line_o
);
    // line idles high, as the pull-up would leave it
    initial line_o = 1'b1;

    task automatic send_bit(input logic b);
        line_o <= b;
        repeat (BIT_CLK) @(posedge clk_i);
    endtask

    task automatic send_char(input logic [8:0] d, input int nb, input logic pen,
                             input logic pbit, input int ns);
        @(posedge clk_i);
        send_bit(1'b0);
        for (int i = 0; i < nb; i++) begin
            send_bit(d[i]);
        end
        if (pen) begin
            send_bit(pbit);
        end
        repeat (ns) send_bit(1'b1);
    endtask

    // waits for a start bit, then samples each bit at its centre
    task automatic recv_char(input int nb, output logic [8:0] d, output logic stp);
        int n;
        n = 0;
        d = 9'h000;
        while (line_i !== 1'b0 && n < 4000) begin
            @(posedge clk_i);
            n++;
        end
        repeat (BIT_CLK / 2) @(posedge clk_i);
        for (int i = 0; i < nb; i++) begin
            repeat (BIT_CLK) @(posedge clk_i);
            d[i] = line_i;
        end
        repeat (BIT_CLK) @(posedge clk_i);
        stp = line_i;
    endtask
endmodule

// ==== test/testbench.sv ====
// self-checking bench for the serial port register slave and its pins
`timescale 1ns/100ps
`include "dsp_defines.svh"
module testbench;
    // ------------------------------------------------------------
    // clock, reset and wiring
    // ------------------------------------------------------------
    localparam int DIV = 1;
    localparam int BIT_CLK = 16 * (DIV + 1);
    logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, rx_line;
    logic        tx_pin, tx_oe, tx_puo, rx_puo, wake, irq;
    logic [7:0]  wb_adr;
    logic [31:0] wb_wdat, wb_dat_o;
    logic [3:0]  pll_tick, wb_sel;
    int          error_cnt, n_tests, cyc_cnt;

    dsp_uart #(.PORT_IDX(0)) u_dsp_uart (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .pll_tick_i(pll_tick),
        .rx_pin_i(rx_line), .tx_pin_o(tx_pin), .tx_pin_oe_o(tx_oe),
        .tx_pullup_off_o(tx_puo), .rx_pullup_off_o(rx_puo), .wake_o(wake), .irq_o(irq));
    dsp_serial_dev #(.BIT_CLK(BIT_CLK)) u_dsp_serial_dev (
        .clk_i(clk_i), .line_i(tx_pin), .line_o(rx_line));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        pll_tick <= pll_tick + 4'h1;
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 30000) begin
            error_cnt++;
            end_sim();
        end
    end
    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic wb_rw(input logic we, input logic [5:0] idx, input logic [7:0] wd,
                         output logic [7:0] rd);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_sel <= 4'hF;
        wb_adr <= {idx, 2'h0};
        wb_wdat <= {24'h000000, wd};
        // ack ends this wait; if it never comes, only the bench timeout does
        do begin
            @(posedge clk_i);
        end while (wb_ack !== 1'b1);
        rd = wb_dat_o[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
        logic [7:0] rd;
        wb_rw(1'b1, idx, wd, rd);
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rd_chk(input string name, input logic [5:0] idx, input logic [7:0] exp);
        logic [7:0] rd;
        wb_rw(1'b0, idx, 8'h00, rd);
        chk(name, exp, rd);
    endtask
    task automatic end_sim();
        $display("tests %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd_chk("status_rst", `DSP_OFF_STATUS, `DSP_STATUS_RST);
        rd_chk("clksel_rst", `DSP_OFF_CLKSEL, 8'h00);
        wr(`DSP_OFF_CLKSEL, 8'hFF);
        rd_chk("clksel_fields", `DSP_OFF_CLKSEL, 8'h77);
        wr(`DSP_OFF_CLKSEL, 8'h00);
        wr(`DSP_OFF_STATUS, 8'h00);
        rd_chk("status_ro", `DSP_OFF_STATUS, `DSP_STATUS_RST);
        rd_chk("unmapped", 6'h3F, 8'h00);
        chk("tx_oe_off", {7'h00, tx_oe}, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_enable();
        wr(`DSP_OFF_DIV, DIV[7:0]);
        rd_chk("divisor", `DSP_OFF_DIV, DIV[7:0]);
        wr(`DSP_OFF_CTL1, 8'h80);
        wr(`DSP_OFF_CTL2, 8'hE9);
        @(posedge clk_i);
        chk("pins_on", {3'h0, wake, irq, tx_oe, tx_puo, rx_puo}, 8'h0F);
        $display("test enable done");
    endtask
    task automatic t_tx();
        logic [8:0] d;
        logic       stp;
        fork
            wr(`DSP_OFF_DATA, 8'hA5);
            u_dsp_serial_dev.recv_char(8, d, stp);
        join
        chk("tx_char", 8'hA5, d[7:0]);
        chk("tx_stop", {7'h00, stp}, 8'h01);
        repeat (2 * BIT_CLK) @(posedge clk_i);
        $display("test tx done");
    endtask
    task automatic t_rx(input logic pen, input logic [7:0] d, input logic [7:0] st);
        u_dsp_serial_dev.send_char({1'b0, d}, 8, pen, ~(^d), 1);
        repeat (4) @(posedge clk_i);
        rd_chk("rx_status", `DSP_OFF_STATUS, st);
        rd_chk("rx_data", `DSP_OFF_DATA, d);
        rd_chk("rx_cleared", `DSP_OFF_STATUS, 8'h0B);
        $display("test rx done");
    endtask
    task automatic t_rx9();
        wr(`DSP_OFF_CTL1, 8'hC8);
        u_dsp_serial_dev.send_char(9'h1A5, 9, 1'b0, 1'b0, 2);
        repeat (4) @(posedge clk_i);
        rd_chk("rx9_status", `DSP_OFF_STATUS, 8'h0F);
        rd_chk("rx9_ninth", `DSP_OFF_CTL1, 8'hCA);
        rd_chk("rx9_data", `DSP_OFF_DATA, 8'hA5);
        $display("test rx9 done");
    endtask
    task automatic t_disable();
        wr(`DSP_OFF_CTL1, 8'h00);
        rd_chk("ctl2_cleared", `DSP_OFF_CTL2, 8'h29);
        rd_chk("status_dis", `DSP_OFF_STATUS, 8'h0B);
        chk("pins_off", {3'h0, wake, irq, tx_oe, tx_puo, rx_puo}, 8'h08);
        $display("test disable done");
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_sel = 4'h0;
        wb_adr = 8'h00;
        wb_wdat = 32'h00000000;
        pll_tick = 4'h0;
        error_cnt = 0;
        n_tests = 0;
        cyc_cnt = 0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_enable();
        t_tx();
        t_rx(1'b0, 8'h96, 8'h0F);
        wr(`DSP_OFF_CTL1, 8'hA0);
        t_rx(1'b1, 8'h3C, 8'h8F);
        t_rx9();
        t_disable();
        end_sim();
    end
endmodule
